// >>> sleep_mode_controller_test.sv
// self-checking bench for the sleep-mode controller
`timescale 1ns/100ps
module sleep_mode_controller_test;
  logic ref_clk, resetn, comparator_power_down, adc_enabled, t2_async;
  logic [7:0] irq_pending, w;
  wire [7:0] mcu_control_register;
  wire sleep_exec, sleep_done, core_halt, irq_release, reset_vector_start;
  wire t2_irq_gate, core_clk_en, io_clk_en, adc_clk_en, osc_en, t2_run;
  wire comparator_en, adc_auto_start, sleeping;
  wire [2:0] active_mode;
  integer n_mismatch = 0, tests_run = 0, seed = 16, i, n, b;
  logic [2:0] m;
  logic arm, slp;
  slmc_sleep_ctrl dut (.*);
  slmc_core_model core (.ref_clk, .sleep_exec, .mcu_control_register,
    .sleep_done);
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // wake sources each mode accepts
  function automatic logic [7:0] wmask(input [2:0] m, input c, t);
    case (m)
      3'h0: wmask = c ? 8'hbf : 8'hff;
      3'h1: wmask = 8'h3f;
      3'h3, 3'h7: wmask = t ? 8'h2f : 8'h0f;
      default: wmask = 8'h0f;
    endcase
  endfunction
  task chk(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task step;
    @(posedge ref_clk);
    #1;
  endtask
  task rst;
    resetn = 0;
    repeat (4) step;
    resetn = 1;
    step;
    chk("rst_vec", 1, reset_vector_start);
    chk("sleeping", 0, sleeping);
  endtask
  initial begin
    {comparator_power_down, adc_enabled, t2_async} = 3'h0;
    irq_pending = 0;
    rst;
    for (i = 0; i < 24; i++) begin
      m = i[2:0];
      arm = i < 16;
      comparator_power_down = i[3];
      adc_enabled = $random(seed);
      t2_async = $random(seed);
      core.do_sleep(arm, m);
      slp = arm && m[2:1] != 2'b10;
      chk("nop", !slp, core.nop_seen);
      chk("sleeping", slp, sleeping);
      chk("core_clk", !slp, core_clk_en);
      if (slp) begin
        chk("mode", m, active_mode);
        chk("adc_start", adc_enabled && m < 2, adc_auto_start);
        chk("core_halt", 1, core_halt);
        chk("io_clk", m == 0, io_clk_en);
        chk("adc_clk", m < 2, adc_clk_en);
        chk("osc", m != 2 && m != 3, osc_en);
        chk("t2_run", m < 2 || ((m == 3 || m == 7) && t2_async), t2_run);
        chk("cmp_en", !comparator_power_down, comparator_en);
        chk("t2_gate", !(m == 1 && !t2_async), t2_irq_gate);
        b = (m == 0) ? 6 : {$random(seed)} % 8;
        if (m == 1 && !t2_async && b == 5) b = 7;
        w = wmask(m, comparator_power_down, t2_async);
        irq_pending = 8'h1 << b;
        step;
        chk("wake", !w[b], sleeping);
        irq_pending = 8'h1;
        if (sleeping) step;
        irq_pending = 0;
        n = 0;
        while (irq_release !== 1 && n < 20) begin
          n++;
          step;
        end
        chk("halt", 4, n);
        if (n == 20) test_done;
        step;
      end
      $display("test %0d done", i);
    end
    core.do_sleep(1, 3'h2);
    rst;
    test_done;
  end
endmodule // sleep_mode_controller_test

// >>> slmc_consts.vh
// constants for the sleep-mode controller
`ifndef SLMC_CONSTS_VH
`define SLMC_CONSTS_VH
// sleep mode select encodings
`define SLMC_MODE_IDLE 3'h0
`define SLMC_MODE_ADCNR 3'h1
`define SLMC_MODE_PDOWN 3'h2
`define SLMC_MODE_PSAVE 3'h3
`define SLMC_MODE_STBY 3'h6
`define SLMC_MODE_XSTBY 3'h7
// control register bit positions
`define SLMC_CTL_ARM_BIT 7
`define SLMC_CTL_MODE_HI 6
`define SLMC_CTL_MODE_LO 4
// halt cycles after wake before the handler runs
`define SLMC_WAKE_HALT 3'h4
// wake-source vector positions
`define SLMC_SRC_EXT_A 0
`define SLMC_SRC_EXT_B 1
`define SLMC_SRC_EXT_C 2
`define SLMC_SRC_TWI 3
`define SLMC_SRC_ADC 4
`define SLMC_SRC_T2 5
`define SLMC_SRC_CMP 6
`define SLMC_SRC_OTHER 7
`define SLMC_NSRC 8
`endif

// >>> slmc_core_model.sv
// behavioural core that executes the sleep instruction
`timescale 1ns/100ps
module slmc_core_model (
  // clock
  input logic ref_clk,
  // handshake with the controller
  output logic sleep_exec,
  output logic [7:0] mcu_control_register,
  input logic sleep_done
);
  logic nop_seen;
  initial begin
    sleep_exec = 0;
    mcu_control_register = 8'h00;
    nop_seen = 0;
  end
  // one-cycle pulse; control image stays as a level afterwards
  task do_sleep(input logic arm, input logic [2:0] m);
    @(posedge ref_clk);
    #1;
    mcu_control_register = {arm, m, 4'h0};
    sleep_exec = 1;
    #2 nop_seen = sleep_done; // nop answer is combinational
    @(posedge ref_clk);
    #1;
    sleep_exec = 0;
  endtask
endmodule // slmc_core_model

// >>> slmc_sleep_ctrl.v
// sleep-mode controller: entry, clock gating, wake and resume
//
// Summary of operation
// - sleep happens only if the arm bit is set when sleep executes
// - three mode select bits choose one of six low-power modes
// - on wake hold core four cycles, run handler, resume after sleep
// - wake keeps registers, memory and I/O contents untouched
// - reset during sleep wakes to the reset vector
// - mode 000 idle: core clock stops, peripherals keep running
// - idle wakes on external and internal peripheral interrupts
// - comparator power-down removes comparator as wake source
// - entering idle or noise reduction starts an enabled conversion
// - mode 001 noise reduction: core stops, converter and some keep running
// - noise reduction wakes only on listed sources
// - timer 2 wakes in noise reduction, irq only if clocked async
// - mode 010 power-down stops oscillator, keeps ext irq and twi wake
// - mode 011 power-save like power-down plus async timer 2
`timescale 1ns/100ps
`include "slmc_consts.vh"
module slmc_sleep_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // control register image from the core
  input wire [7:0] mcu_control_register,
  input wire comparator_power_down,
  input wire adc_enabled,
  input wire t2_async,
  // core handshake
  input wire sleep_exec,
  input wire [`SLMC_NSRC-1:0] irq_pending,
  output wire sleep_done,
  output reg core_halt,
  output reg irq_release,
  output reg reset_vector_start,
  output reg t2_irq_gate,
  // clock domain enables
  output reg core_clk_en,
  output reg io_clk_en,
  output reg adc_clk_en,
  output reg osc_en,
  output reg t2_run,
  output reg comparator_en,
  output reg adc_auto_start,
  // status
  output reg sleeping,
  output reg [2:0] active_mode
);
  //////////////////////////////////////////////////////////////////////
  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_HALT = 2'h2;
  localparam ST_RESUME = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [2:0] halt_cnt_reg;
  reg [2:0] halt_cnt_next;
  reg reset_seen_reg;
  wire arm = mcu_control_register[`SLMC_CTL_ARM_BIT];
  wire [2:0] mode_select_field =
    mcu_control_register[`SLMC_CTL_MODE_HI:`SLMC_CTL_MODE_LO];
  wire wake;
  wire t2_irq_ok;

  // legal encodings; 100 and 101 are not modes
  function is_mode;
    input [2:0] m;
    begin
      is_mode = (m != 3'h4) && (m != 3'h5);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // wake qualification per mode; mode_next equals mode_reg while asleep,
  // and on entry it already carries the new mode for the timer 2 gate
  slmc_wake_filter u_filter (
    .mode(mode_next),
    .cmp_power_down(comparator_power_down),
    .t2_async(t2_async),
    .irq_pending(irq_pending),
    .wake(wake),
    .t2_irq_allowed(t2_irq_ok)
  );

  // sleep with arm clear or a bad mode completes at once
  assign sleep_done = sleep_exec && (state_reg == ST_RUN) &&
    !(arm && is_mode(mode_select_field));

  //////////////////////////////////////////////////////////////////////
  // sequencer; only clocks are gated, no state is touched
  always @* begin
    state_next = state_reg;
    mode_next = mode_reg;
    halt_cnt_next = halt_cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (sleep_exec && arm && is_mode(mode_select_field)) begin
          state_next = ST_SLEEP;
          mode_next = mode_select_field;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_next = ST_HALT;
          halt_cnt_next = 3'h1;
        end
      end
      ST_HALT: begin
        if (halt_cnt_reg == `SLMC_WAKE_HALT) begin
          state_next = ST_RESUME;
        end else begin
          halt_cnt_next = halt_cnt_reg + 3'h1;
        end
      end
      default: state_next = ST_RUN; // handler then next instruction
    endcase
  end

  // state registers; reset in sleep lands in run, vector flagged
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_RUN;
      mode_reg <= `SLMC_MODE_IDLE;
      halt_cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      halt_cnt_reg <= halt_cnt_next;
    end
  end

  // first cycle after reset release starts at the reset vector
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_seen_reg <= 1'b0;
      reset_vector_start <= 1'b0;
    end else begin
      reset_seen_reg <= 1'b1;
      reset_vector_start <= !reset_seen_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // clock enables by state and mode, registered for glitch-free gating
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      core_clk_en <= 1'b1;
      io_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      osc_en <= 1'b1;
      t2_run <= 1'b1;
      comparator_en <= 1'b1;
      adc_auto_start <= 1'b0;
      core_halt <= 1'b0;
      irq_release <= 1'b0;
      sleeping <= 1'b0;
      active_mode <= `SLMC_MODE_IDLE;
      t2_irq_gate <= 1'b1;
    end else begin
      comparator_en <= !comparator_power_down;
      sleeping <= (state_next == ST_SLEEP);
      active_mode <= mode_next;
      core_halt <= (state_next != ST_RUN) && (state_next != ST_RESUME);
      irq_release <= (state_next == ST_RESUME);
      // enabled converter starts on entry to idle or noise reduction
      adc_auto_start <= (state_reg == ST_RUN) &&
        (state_next == ST_SLEEP) && adc_enabled &&
        ((mode_next == `SLMC_MODE_IDLE) ||
         (mode_next == `SLMC_MODE_ADCNR));
      t2_irq_gate <= (state_next == ST_RUN) || t2_irq_ok;
      if (state_next == ST_SLEEP) begin
        core_clk_en <= 1'b0;
        case (mode_next)
          `SLMC_MODE_IDLE: begin
            io_clk_en <= 1'b1;
            adc_clk_en <= 1'b1;
            osc_en <= 1'b1;
            t2_run <= 1'b1;
          end
          `SLMC_MODE_ADCNR: begin
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b1;
            osc_en <= 1'b1;
            t2_run <= 1'b1;
          end
          `SLMC_MODE_PDOWN: begin
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
            osc_en <= 1'b0;
            t2_run <= 1'b0;
          end
          `SLMC_MODE_PSAVE: begin
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
            osc_en <= 1'b0;
            t2_run <= t2_async;
          end
          `SLMC_MODE_STBY: begin
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
            osc_en <= 1'b1;
            t2_run <= 1'b0;
          end
          default: begin
            io_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
            osc_en <= 1'b1;
            t2_run <= t2_async;
          end
        endcase
      end else begin
        // halt and resume keep core clock off only while halted
        core_clk_en <= (state_next != ST_HALT);
        io_clk_en <= 1'b1;
        adc_clk_en <= 1'b1;
        osc_en <= 1'b1;
        t2_run <= 1'b1;
      end
    end
  end
  // no storage reset or write path exists here; clocks only gate
endmodule // slmc_sleep_ctrl

// >>> slmc_sleep_ctrl_assertions.sv
// checker for the sleep-mode controller ports
`timescale 1ns/100ps
module slmc_checker (
  // clock and reset
  input logic ref_clk, resetn,
  // core side
  input logic sleep_exec, t2_async, comparator_power_down, adc_enabled,
  input logic [7:0] mcu_control_register, irq_pending,
  // results
  input logic sleep_done, core_halt, irq_release, sleeping, t2_irq_gate,
  input logic core_clk_en, io_clk_en, adc_clk_en, osc_en, adc_auto_start,
  input logic [2:0] active_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // accepted sleep: armed, run state, not the two unused encodings
  wire run = !sleeping && !core_halt && !irq_release;
  wire arm = mcu_control_register[7];
  wire [2:0] sel = mcu_control_register[6:4];
  wire take = sleep_exec && run && arm && sel[2:1] != 2'b10;
  wire slp0 = sleeping && active_mode == 3'h0;
  wire slp1 = sleeping && active_mode == 3'h1;
  sequence halt_s; core_halt [*4]; endsequence
  sequence rel_s; irq_release && !core_halt; endsequence
  ////////////////////////////////////////////////////////////////////////
  nop_done_a: assert property (sleep_exec && run && !arm |-> sleep_done)
    else $error("disarmed sleep not a nop");
  enter_a: assert property (take |=> sleeping && core_halt &&
    active_mode == $past(sel)) else $error("sleep entry wrong");
  idle_clk_a: assert property (slp0 |-> !core_clk_en && io_clk_en &&
    adc_clk_en) else $error("idle clocks wrong");
  nr_run_a: assert property (slp1 |-> !core_clk_en && adc_clk_en)
    else $error("noise reduction clocks wrong");
  pd_osc_a: assert property (sleeping && active_mode == 3'h2 |-> !osc_en)
    else $error("oscillator runs in power-down");
  wake_seq_a: assert property ($fell(sleeping) |-> halt_s ##1 rel_s)
    else $error("wake halt sequence wrong");
  idle_wake_a: assert property (slp0 && irq_pending[0] |=> !sleeping)
    else $error("idle did not wake");
  nr_mask_a: assert property (slp1 && irq_pending[5:0] == 6'h0
    |=> sleeping) else $error("noise reduction woke wrongly");
  cmp_off_a: assert property (slp0 && comparator_power_down &&
    irq_pending == 8'h40 |=> sleeping) else $error("comparator woke");
  auto_start_a: assert property (take && adc_enabled && sel[2:1] == 2'b00
    |=> adc_auto_start) else $error("no conversion start");
  t2_gate_a: assert property (slp1 && !t2_async |-> !t2_irq_gate)
    else $error("timer 2 irq gate open");
endmodule // slmc_checker
bind slmc_sleep_ctrl slmc_checker chk_i (.*);

// >>> slmc_wake_filter.v
// wake-source qualifier: which pending events may wake each mode
`timescale 1ns/100ps
`include "slmc_consts.vh"
module slmc_wake_filter (
  // selected mode
  input wire [2:0] mode,
  input wire cmp_power_down,
  input wire t2_async,
  // pending interrupt flags and enables
  input wire [`SLMC_NSRC-1:0] irq_pending,
  // results
  output reg wake,
  output reg t2_irq_allowed
);
  reg [`SLMC_NSRC-1:0] allow;

  // deep-mode mask, shared by power-down and its relatives
  function [`SLMC_NSRC-1:0] deep_mask;
    input with_t2;
    begin
      deep_mask = 8'h0f;
      deep_mask[`SLMC_SRC_T2] = with_t2;
    end
  endfunction

  // allowed sources per mode
  always @* begin
    allow = 8'h00;
    t2_irq_allowed = 1'b1;
    case (mode)
      `SLMC_MODE_IDLE: begin
        allow = 8'hff;
        allow[`SLMC_SRC_CMP] = ~cmp_power_down;
      end
      `SLMC_MODE_ADCNR: begin
        allow = 8'h3f;
        t2_irq_allowed = t2_async;
      end
      `SLMC_MODE_PDOWN: allow = deep_mask(1'b0);
      `SLMC_MODE_PSAVE: allow = deep_mask(t2_async);
      `SLMC_MODE_STBY: allow = deep_mask(1'b0);
      `SLMC_MODE_XSTBY: allow = deep_mask(t2_async);
      default: allow = 8'h00;
    endcase
    wake = |(allow & irq_pending);
  end
endmodule // slmc_wake_filter
